// ---- design/trap_seq_pkg.sv ----
// constants shared by the trap and interrupt sequencer
package trap_seq_pkg;

   localparam int          IRQ_N          = 8;
   localparam int          TRAP_N         = 4;

   // ------------------------------------------------------------
   // register byte addresses
   // ------------------------------------------------------------
   localparam logic [11:0] ADDR_CTRL      = 12'h000;
   localparam logic [11:0] ADDR_PRIO      = 12'h004;
   localparam logic [11:0] ADDR_TRAP      = 12'h008;
   localparam logic [11:0] ADDR_RESET     = 12'h00c;
   localparam logic [11:0] ADDR_FLAG      = 12'h010;
   localparam logic [11:0] ADDR_ENABLE    = 12'h014;
   localparam logic [11:0] ADDR_IRQ_PRIO  = 12'h018;
   localparam logic [11:0] ADDR_STACK_LIM = 12'h01c;

   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int          CTRL_ALT_BIT   = 0;
   localparam int          CTRL_OVF31_BIT = 1;
   localparam int          CTRL_OVF39_BIT = 2;
   localparam int          PRIO_TOP_BIT   = 3;
   localparam int          CONFLICT_BIT   = 15;
   localparam logic [2:0]  LEVEL_RESET    = 3'h0;
   localparam logic [2:0]  IRQ_PRIO_RESET = 3'h4;
   localparam logic [15:0] STACK_LIM_RESET = 16'hfffe;

   // ------------------------------------------------------------
   // trap levels, index order math, address, stack, oscillator; first interrupt vector
   // ------------------------------------------------------------
   localparam int          TRAP_MATH      = 0;
   localparam int          TRAP_ADDR      = 1;
   localparam int          TRAP_STACK     = 2;
   localparam int          TRAP_OSC       = 3;
   localparam logic [3:0]  LVL_MATH       = 4'hb;
   localparam logic [3:0]  LVL_HARD_MIN   = 4'hc;
   localparam logic [3:0]  LVL_TRAP_MIN   = 4'h8;
   localparam logic [5:0]  IRQ_VEC_FIRST  = 6'h08;

   // ------------------------------------------------------------
   // memory map used by the vector tables and the error checks
   // ------------------------------------------------------------
   localparam logic [23:0] DEF_TABLE_BASE = 24'h000004;
   localparam logic [23:0] ALT_TABLE_BASE = 24'h000084;
   localparam logic [23:0] VEC_REGION_END = 24'h000100;
   localparam logic [23:0] PROG_TOP       = 24'h003fff;
   localparam logic [15:0] STACK_FLOOR    = 16'h0800;
   localparam logic [15:0] X_LO           = 16'h0800;
   localparam logic [15:0] X_HI           = 16'h0bff;
   localparam logic [15:0] Y_LO           = 16'h0c00;
   localparam logic [15:0] Y_HI           = 16'h0fff;
   localparam logic [15:0] DATA_TOP       = 16'h0fff;
   localparam logic [4:0]  SHIFT_MAX      = 5'h10;

endpackage

// ---- design/trap_and_interrupt_sequencer.sv ----
// trap detection, trap and interrupt priority sequencing, apb registers
//
// Behaviour
// - traps run at levels 8 to 15, so the top priority bit is set.
// - level 7 outside a trap blocks all interrupts, traps still taken.
// - trap processing begins only after the faulting instruction completes.
// - divide by zero raises the math error trap.
// - enabled bit 31 accumulator overflow with guard bits unused raises math trap.
// - enabled bit 39 overflow with saturation off raises math trap.
// - shift count above the maximum raises a trap.
// - misaligned word, bad data read, bad program access, vector fetch: address trap.
// - dual operand access treats the other data region as unimplemented.
// - branch, jump or execution at unimplemented program address: address trap.
// - stack pointer above limit or below 0x0800 raises stack trap.
// - oscillator failure with fallback to backup clock raises trap.
// - simultaneous traps are taken by fixed priority, rest stay pending.
// - levels 8 to 11 are soft traps; math error is level 11.
// - levels 12 to 15 are hard; address 12, stack 13, oscillator 14.
// - lower hard trap during higher pending or serviced trap is a conflict.
// - a conflict resets the device and sets reset status bit 15.
// - flags sampled each cycle; flag with enable forms a request.
// - interrupt only when request priority exceeds the processor level.
// - entry pushes program counter and status low byte, loads new level.
// - top priority bit clear for interrupts; handlers clear flags first.
// - alternate vector select switches all vectors to the alternate table.
module trap_and_interrupt_sequencer
   import trap_seq_pkg::*;
(
   input  wire logic                    sys_clk,
   input  wire logic                    reset_n,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [11:0]             paddr,
   input  wire logic [31:0]             pwdata,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   input  wire logic                    instr_done,
   input  wire logic [23:0]             core_pc,
   input  wire logic [4:0]              status_flags,
   input  wire logic                    div_zero,
   input  wire logic [1:0]              acc_ovf31,
   input  wire logic                    guard_unused,
   input  wire logic [1:0]              acc_ovf39,
   input  wire logic                    sat_disabled,
   input  wire logic                    shift_vld,
   input  wire logic [4:0]              shift_count,
   input  wire logic                    data_acc,
   input  wire logic                    data_rd,
   input  wire logic                    data_word,
   input  wire logic                    dual_x_access,
   input  wire logic                    dual_y_access,
   input  wire logic [15:0]             data_addr,
   input  wire logic                    prog_acc,
   input  wire logic [23:0]             prog_addr,
   input  wire logic                    fetch_vld,
   input  wire logic [23:0]             fetch_addr,
   input  wire logic                    flow_lit_vld,
   input  wire logic [23:0]             flow_lit_addr,
   input  wire logic                    sp_load,
   input  wire logic [15:0]             sp_value,
   input  wire logic                    osc_fail,
   input  wire logic                    return_from_irq_op,
   input  wire logic [7:0]              ret_status_low,
   input  wire logic                    ret_top_bit,
   input  wire logic [IRQ_N-1:0]        irq_event,
   output logic                         exc_take,
   output logic      [23:0]             exc_vector,
   output logic      [23:0]             push_pc,
   output logic      [7:0]              status_low_byte,
   output logic                         push_top_bit,
   output logic      [2:0]              cpu_priority_level,
   output logic                         priority_top_bit,
   output logic                         device_reset_req
);
   import trap_seq_pkg::*;

   typedef struct packed {
      logic              alt_vector_select;
      logic              ovf31_en;
      logic              ovf39_en;
      logic [2:0]        lvl;
      logic              top;
      logic [TRAP_N-1:0] trap_pend;
      logic              trap_conflict_reset_flag;
      logic [IRQ_N-1:0]  irq_flag_regs;
      logic [IRQ_N-1:0]  irq_enable_regs;
      logic [3*IRQ_N-1:0] irq_prio;
      logic [15:0]       stack_limit_reg;
      logic              osc_seen;
      logic              take;
      logic [23:0]       vec;
      logic [23:0]       pc;
      logic [7:0]        slb;
      logic              ptop;
      logic              rst_req;
      logic [31:0]       rdata;
      logic              ready;
      logic              err;
   } state_t;

   state_t st;
   state_t next_st;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic prog_bad(input logic [23:0] a);
      prog_bad = (a > PROG_TOP);
   endfunction

   function automatic logic [23:0] vec_addr(input logic alt,
                                            input logic [5:0] n);
      vec_addr = (alt ? ALT_TABLE_BASE : DEF_TABLE_BASE) +
                 {17'h0, n, 1'b0};
   endfunction

   function automatic logic [3:0] trap_lvl(input int i);
      trap_lvl = LVL_MATH + 4'(i);
   endfunction

   function automatic logic data_bad(input logic [15:0] a,
                                     input logic x, input logic y);
      if (x)
         data_bad = (a < X_LO) || (a > X_HI);
      else if (y)
         data_bad = (a < Y_LO) || (a > Y_HI);
      else
         data_bad = (a > DATA_TOP);
   endfunction

   // ------------------------------------------------------------
   // combinational decisions
   // ------------------------------------------------------------
   logic [TRAP_N-1:0] trap_new;
   logic [3:0]        cur_level;
   logic [3:0]        trap_best;
   logic [1:0]        trap_idx;
   logic              trap_any;
   logic              trap_take;
   logic [2:0]        irq_best;
   logic [2:0]        irq_idx;
   logic [IRQ_N-1:0]  irq_req;
   logic              irq_take;
   logic              conflict;
   logic              wr;
   logic              rd_setup;

   always_comb begin
      cur_level = {st.top, st.lvl};
      trap_new[TRAP_MATH] = div_zero
         || (st.ovf31_en && (|acc_ovf31) && guard_unused)
         || (st.ovf39_en && (|acc_ovf39) && sat_disabled)
         || (shift_vld && (shift_count > SHIFT_MAX));
      trap_new[TRAP_ADDR] =
         (data_acc && data_word && data_addr[0])
         || (data_acc && data_rd &&
             data_bad(data_addr, dual_x_access, dual_y_access))
         || (prog_acc && prog_bad(prog_addr))
         || (fetch_vld && (fetch_addr < VEC_REGION_END))
         || (fetch_vld && prog_bad(fetch_addr))
         || (flow_lit_vld && prog_bad(flow_lit_addr));
      trap_new[TRAP_STACK] = sp_load &&
         ((sp_value > st.stack_limit_reg) || (sp_value < STACK_FLOOR));
      trap_new[TRAP_OSC] = osc_fail && !st.osc_seen;

      // highest pending trap wins, the others wait
      trap_any  = 1'b0;
      trap_idx  = 2'h0;
      trap_best = 4'h0;
      for (int i = 0; i < TRAP_N; i++) begin
         if (st.trap_pend[i]) begin
            trap_any  = 1'b1;
            trap_idx  = 2'(i);
            trap_best = trap_lvl(i);
         end
      end
      // fault completes first: take only on the instruction boundary
      trap_take = instr_done && trap_any && (trap_best > cur_level);

      // lower hard trap against higher pending or serviced trap
      conflict = 1'b0;
      for (int i = TRAP_ADDR; i < TRAP_N; i++) begin
         if (trap_new[i] && trap_lvl(i) >= LVL_HARD_MIN) begin
            if (cur_level >= LVL_HARD_MIN && cur_level > trap_lvl(i))
               conflict = 1'b1;
            for (int j = i + 1; j < TRAP_N; j++)
               if (st.trap_pend[j])
                  conflict = 1'b1;
         end
      end

      irq_req  = st.irq_flag_regs & st.irq_enable_regs;
      irq_best = 3'h0;
      irq_idx  = 3'h0;
      for (int i = IRQ_N - 1; i >= 0; i--) begin
         // ties go to the lower index, natural order
         if (irq_req[i] && st.irq_prio[3*i +: 3] >= irq_best) begin
            irq_best = st.irq_prio[3*i +: 3];
            irq_idx  = 3'(i);
         end
      end
      // a trap level always exceeds any 3 bit request, so level 7 or
      // any trap in service masks every interrupt
      irq_take = instr_done && !trap_take && !conflict &&
                 ({1'b0, irq_best} > cur_level);

      wr       = psel && penable && st.ready && pwrite;
      rd_setup = psel && !penable;
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_st          = st;
      next_st.osc_seen = osc_fail;
      next_st.take     = 1'b0;
      next_st.rst_req  = 1'b0;

      // set beats a software clear in the same cycle
      if (wr && paddr == ADDR_FLAG)
         next_st.irq_flag_regs = st.irq_flag_regs & ~pwdata[IRQ_N-1:0];
      next_st.irq_flag_regs = next_st.irq_flag_regs | irq_event;
      if (wr && paddr == ADDR_RESET && pwdata[CONFLICT_BIT])
         next_st.trap_conflict_reset_flag = 1'b0;

      if (wr) begin
         if (paddr == ADDR_CTRL) begin
            next_st.alt_vector_select = pwdata[CTRL_ALT_BIT];
            next_st.ovf31_en          = pwdata[CTRL_OVF31_BIT];
            next_st.ovf39_en          = pwdata[CTRL_OVF39_BIT];
         end else if (paddr == ADDR_PRIO) begin
            next_st.lvl = pwdata[2:0];
         end else if (paddr == ADDR_ENABLE) begin
            next_st.irq_enable_regs = pwdata[IRQ_N-1:0];
         end else if (paddr == ADDR_IRQ_PRIO) begin
            next_st.irq_prio = pwdata[3*IRQ_N-1:0];
         end else if (paddr == ADDR_STACK_LIM) begin
            next_st.stack_limit_reg = pwdata[15:0];
         end
      end

      if (return_from_irq_op) begin
         next_st.lvl = ret_status_low[7:5];
         next_st.top = ret_top_bit;
      end

      next_st.trap_pend = st.trap_pend;
      if (trap_take)
         next_st.trap_pend[trap_idx] = 1'b0;
      next_st.trap_pend = next_st.trap_pend | trap_new;

      if (trap_take || irq_take) begin
         next_st.take = 1'b1;
         next_st.pc   = core_pc;
         next_st.slb  = {st.lvl, status_flags};
         next_st.ptop = st.top;
      end
      if (trap_take) begin
         next_st.lvl = trap_best[2:0];
         next_st.top = 1'b1;
         // trap vector number is its level less eight
         next_st.vec = vec_addr(st.alt_vector_select,
                                {2'h0, trap_best - LVL_TRAP_MIN});
      end else if (irq_take) begin
         next_st.lvl = irq_best;
         next_st.top = 1'b0;
         next_st.vec = vec_addr(st.alt_vector_select,
                                IRQ_VEC_FIRST + {3'h0, irq_idx});
      end

      if (conflict) begin
         next_st.rst_req                  = 1'b1;
         next_st.trap_conflict_reset_flag = 1'b1;
         next_st.trap_pend                = '0;
         next_st.lvl                      = LEVEL_RESET;
         next_st.top                      = 1'b0;
         next_st.take                     = 1'b0;
      end

      // apb answers in the access phase straight after setup
      next_st.ready = rd_setup;
      next_st.err   = 1'b0;
      next_st.rdata = 32'h0;
      if (rd_setup) begin
         if (paddr == ADDR_CTRL)
            next_st.rdata = {29'h0, st.ovf39_en, st.ovf31_en,
                             st.alt_vector_select};
         else if (paddr == ADDR_PRIO)
            next_st.rdata = {28'h0, st.top, st.lvl};
         else if (paddr == ADDR_TRAP)
            next_st.rdata = {28'h0, st.trap_pend};
         else if (paddr == ADDR_RESET)
            next_st.rdata = {16'h0, st.trap_conflict_reset_flag, 15'h0};
         else if (paddr == ADDR_FLAG)
            next_st.rdata = {24'h0, st.irq_flag_regs};
         else if (paddr == ADDR_ENABLE)
            next_st.rdata = {24'h0, st.irq_enable_regs};
         else if (paddr == ADDR_IRQ_PRIO)
            next_st.rdata = {8'h0, st.irq_prio};
         else if (paddr == ADDR_STACK_LIM)
            next_st.rdata = {16'h0, st.stack_limit_reg};
         else
            next_st.err = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         st                 <= '0;
         st.irq_prio        <= {IRQ_N{IRQ_PRIO_RESET}};
         st.stack_limit_reg <= STACK_LIM_RESET;
         st.lvl             <= LEVEL_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign prdata             = st.rdata;
   assign pready             = st.ready;
   assign pslverr            = st.err;
   assign exc_take           = st.take;
   assign exc_vector         = st.vec;
   assign push_pc            = st.pc;
   assign status_low_byte    = st.slb;
   assign push_top_bit       = st.ptop;
   assign cpu_priority_level = st.lvl;
   assign priority_top_bit   = st.top;
   assign device_reset_req   = st.rst_req;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   a_trap_sets_top: assert property (trap_take && !return_from_irq_op |=>
      priority_top_bit && exc_take) else $error("trap without top bit");
   a_level7_blocks: assert property (!st.top && st.lvl == 3'h7 |->
      !irq_take) else $error("interrupt taken at level 7");
   a_on_boundary: assert property (exc_take |-> $past(instr_done))
      else $error("exception off instruction boundary");
   a_div_zero_math: assert property (div_zero && !conflict |=>
      st.trap_pend[TRAP_MATH]) else $error("divide by zero lost");
   a_misalign_addr: assert property (data_acc && data_word &&
      data_addr[0] && !conflict |=> st.trap_pend[TRAP_ADDR])
      else $error("misaligned access lost");
   a_stack_floor: assert property (sp_load && sp_value < STACK_FLOOR
      && !conflict |=> st.trap_pend[TRAP_STACK])
      else $error("stack underflow lost");
   a_conflict_reset: assert property (conflict |=> device_reset_req
      ##1 !device_reset_req && st.trap_conflict_reset_flag)
      else $error("conflict did not reset");
   a_irq_entry: assert property (irq_take && !return_from_irq_op |=>
      cpu_priority_level == $past(irq_best) && !priority_top_bit
      && status_low_byte[7:5] == $past(st.lvl))
      else $error("interrupt entry level wrong");
   a_alt_table: assert property (exc_take && $past(st.alt_vector_select)
      |-> exc_vector >= ALT_TABLE_BASE) else $error("wrong vector table");

   c_trap_taken:  cover property (trap_take);
   c_irq_taken:   cover property (irq_take ##[1:20] return_from_irq_op);
   c_conflict:    cover property (conflict);

endmodule

// ---- dv/core_model.sv ----
// processor core model: instruction boundaries, frame stack, returns
module core_model (
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   input  wire logic        slow,
   input  wire logic        do_ret,
   input  wire logic        exc_take,
   input  wire logic        device_reset_req,
   input  wire logic [7:0]  status_low_byte,
   input  wire logic        push_top_bit,
   output logic             instr_done,
   output logic [23:0]      core_pc,
   output logic [4:0]       status_flags,
   output logic             return_from_irq_op,
   output logic [7:0]       ret_status_low,
   output logic             ret_top_bit
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [8:0] frames[$];
   logic [1:0] tick;
   assign status_flags = 5'h0a;
   initial {instr_done, core_pc, return_from_irq_op, tick} = '0;
   initial {ret_status_low, ret_top_bit} = '0;
   // a conflict reset throws away every frame the core had stacked
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n || device_reset_req) begin
         frames.delete();
         instr_done <= 1'h0;
         return_from_irq_op <= 1'h0;
      end else begin
         tick <= tick + 2'h1;
         instr_done <= !slow || tick == 2'h3;
         core_pc <= core_pc + 24'h2;
         return_from_irq_op <= 1'h0;
         if (exc_take)
            frames.push_back({push_top_bit, status_low_byte});
         // only returns when the bench says the handler is done
         if (do_ret && frames.size() > 0) begin
            {ret_top_bit, ret_status_low} <= frames.pop_back();
            return_from_irq_op <= 1'h1;
         end
      end
   end
endmodule

// ---- dv/tb_top.sv ----
// self-checking bench: traps, interrupts, vector tables, conflict reset
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import trap_seq_pkg::*;
   logic        sys_clk = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0;
   logic        pwrite = 1'h0, pready, pslverr, instr_done, div_zero = 1'h0;
   logic        guard_unused = 1'h0, sat_disabled = 1'h0, shift_vld = 1'h0;
   logic        data_acc = 1'h0, data_rd = 1'h0, data_word = 1'h0, err;
   logic        dual_x_access = 1'h0, dual_y_access = 1'h0, prog_acc = 1'h0;
   logic        fetch_vld = 1'h0, flow_lit_vld = 1'h0, sp_load = 1'h0;
   logic        osc_fail = 1'h0, return_from_irq_op, ret_top_bit, exc_take;
   logic        push_top_bit, priority_top_bit, device_reset_req;
   logic        slow = 1'h0, do_ret = 1'h0;
   logic [1:0]  acc_ovf31 = 2'h0, acc_ovf39 = 2'h0;
   logic [4:0]  status_flags, shift_count = 5'h00;
   logic [7:0]  ret_status_low, status_low_byte, irq_event = 8'h00;
   logic [2:0]  cpu_priority_level;
   logic [11:0] paddr = 12'h000;
   logic [15:0] data_addr = 16'h0000, sp_value = 16'h0800;
   logic [23:0] core_pc, prog_addr = 24'h0, fetch_addr = 24'h0;
   logic [23:0] flow_lit_addr = 24'h0, exc_vector, push_pc;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   int          fail_count = 0, n_tests = 0;

   trap_and_interrupt_sequencer trap_and_interrupt_sequencer_i (
      .sys_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .instr_done, .core_pc, .status_flags, .div_zero,
      .acc_ovf31, .guard_unused, .acc_ovf39, .sat_disabled, .shift_vld,
      .shift_count, .data_acc, .data_rd, .data_word, .dual_x_access,
      .dual_y_access, .data_addr, .prog_acc, .prog_addr, .fetch_vld,
      .fetch_addr, .flow_lit_vld, .flow_lit_addr, .sp_load, .sp_value,
      .osc_fail, .return_from_irq_op, .ret_status_low, .ret_top_bit,
      .irq_event, .exc_take, .exc_vector, .push_pc, .status_low_byte,
      .push_top_bit, .cpu_priority_level, .priority_top_bit,
      .device_reset_req);
   core_model core_model_i (
      .sys_clk, .reset_n, .slow, .do_ret, .exc_take, .device_reset_req,
      .status_low_byte, .push_top_bit, .instr_done, .core_pc,
      .status_flags, .return_from_irq_op, .ret_status_low, .ret_top_bit);

   always #5 sys_clk = ~sys_clk;
   initial begin
      #200000;
      fail_count++;
      end_sim();
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp,
                      input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   // read data and error are taken at the edge that samples pready
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd);
      @(posedge sys_clk);
      {psel, pwrite, paddr, pwdata} <= {1'h1, wr, a, wd};
      @(posedge sys_clk);
      penable <= 1'h1;
      // no wait-state count assumed; only the watchdog ends a hang
      do
         @(posedge sys_clk);
      while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'h0;
   endtask

   function automatic logic sig(input int s);
      if (s == 0)
         return exc_take;
      if (s == 1)
         return device_reset_req;
      return cpu_priority_level === 3'h0;
   endfunction

   task automatic await(input int s, input string name);
      // look before the first edge too: a one-cycle pulse may already stand
      for (int i = 0; i < 12; i++) begin
         #1;
         if (sig(s) === 1'h1)
            break;
         @(posedge sys_clk);
      end
      chk(name, 32'h1, {31'h0, sig(s)});
   endtask

   // -----------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------
   task automatic fire(input int k);
      @(posedge sys_clk);
      case (k)
         0: div_zero <= 1'h1;
         1: {guard_unused, acc_ovf31} <= 3'h6;
         2: {sat_disabled, acc_ovf39} <= 3'h5;
         3: {shift_vld, shift_count} <= 6'h31;
         4: {data_acc, data_rd, data_word, data_addr} <= 19'h70801;
         5: {data_acc, data_rd, dual_x_access, data_addr} <= 19'h70c00;
         6: {prog_acc, prog_addr} <= 25'h1004000;
         7: {fetch_vld, fetch_addr} <= 25'h1000080;
         8: {flow_lit_vld, flow_lit_addr} <= 25'h1004000;
         9: {sp_load, sp_value} <= 17'h107fe;
         10: {sp_load, sp_value} <= 17'h10a00;
         11: osc_fail <= 1'h1;
         default: {osc_fail, sp_load, sp_value} <= 18'h307fe;
      endcase
      @(posedge sys_clk);
      {div_zero, acc_ovf31, acc_ovf39, shift_vld, data_acc, data_rd,
       data_word, dual_x_access, prog_acc, fetch_vld, flow_lit_vld,
       sp_load, osc_fail} <= '0;
   endtask

   task automatic ret();
      @(posedge sys_clk);
      do_ret <= 1'h1;
      @(posedge sys_clk);
      do_ret <= 1'h0;
      await(2, "returned");
      chk("top after return", 32'h0, {31'h0, priority_top_bit});
   endtask

   task automatic trap_pass(input logic [23:0] base);
      logic [3:0] v;
      for (int k = 0; k < 12; k++) begin
         v = k < 4 ? 4'h3 : k < 9 ? 4'h4 : k < 11 ? 4'h5 : 4'h6;
         fire(k);
         await(0, "trap taken");
         chk("vector", {8'h0, base + {v, 1'h0}}, {8'h0, exc_vector});
         chk("level", {29'h0, v[2:0]}, {29'h0, cpu_priority_level});
         chk("top", 32'h1, {31'h0, priority_top_bit});
         // core pc advances by two each cycle, so the stacked one is behind
         chk("pushed pc", {8'h0, core_pc - 24'h2}, {8'h0, push_pc});
         ret();
      end
   endtask

   task automatic irq_case();
      apb(1'h1, ADDR_ENABLE, 32'h4);
      apb(1'h1, ADDR_PRIO, 32'h7);
      @(posedge sys_clk);
      irq_event <= 8'h04;
      @(posedge sys_clk);
      irq_event <= 8'h00;
      repeat (6) begin
         @(posedge sys_clk);
         #1;
         chk("held off", 32'h0, {31'h0, exc_take});
      end
      apb(1'h0, ADDR_FLAG, 32'h0);
      chk("flag", 32'h4, rd);
      apb(1'h1, ADDR_PRIO, 32'h0);
      await(0, "irq taken");
      chk("irq vector", 32'h18, {8'h0, exc_vector});
      chk("irq level", 32'h4, {29'h0, cpu_priority_level});
      chk("stacked", 32'h0a, {24'h0, status_low_byte});
      chk("irq top", 32'h0, {31'h0, priority_top_bit});
      apb(1'h1, ADDR_FLAG, 32'h4);
      ret();
   endtask

   task automatic conflict();
      fire(12);
      await(0, "osc first");
      chk("first vector", 32'h10, {8'h0, exc_vector});
      apb(1'h0, ADDR_TRAP, 32'h0);
      chk("left pending", 32'h4, rd);
      ret();
      await(0, "stack next");
      chk("next vector", 32'h0e, {8'h0, exc_vector});
      ret();
      fire(11);
      await(0, "osc taken");
      fire(9);
      await(1, "conflict reset");
      apb(1'h0, ADDR_RESET, 32'h0);
      chk("conflict flag", 32'h8000, rd);
      apb(1'h1, ADDR_RESET, 32'h8000);
      apb(1'h0, ADDR_RESET, 32'h0);
      chk("flag cleared", 32'h0, rd);
   endtask

   initial begin
      repeat (6) @(posedge sys_clk);
      reset_n <= 1'h1;
      apb(1'h0, ADDR_IRQ_PRIO, 32'h0);
      chk("prio reset", 32'h924924, rd);
      apb(1'h0, 12'h020, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, err});
      apb(1'h1, ADDR_STACK_LIM, 32'h0900);
      apb(1'h1, ADDR_CTRL, 32'h6);
      trap_pass(DEF_TABLE_BASE);
      slow <= 1'h1;
      apb(1'h1, ADDR_CTRL, 32'h7);
      trap_pass(ALT_TABLE_BASE);
      slow <= 1'h0;
      apb(1'h1, ADDR_CTRL, 32'h0);
      irq_case();
      conflict();
      end_sim();
   end
endmodule
